// file: mfct_counter_timer.sv
/*
  mfct_counter_timer: 32-bit counter/timer with 16-line input debounce.
  Assumes register accesses arrive as one-cycle requests on regReq and
  field lines dioIn are synchronous to clock.
*/
`timescale 1ns/1ns
module mfct_counter_timer #(
    parameter int DB_1MS_CYC = mfct_pkg::DB_1MS_CYC,   // 1 ms debounce count
    parameter int DB_8MS_CYC = mfct_pkg::DB_8MS_CYC    // 8 ms debounce count
) (
    input  wire logic                clock,
    input  wire logic                nrst,
    input  wire mfct_pkg::mfct_req_s regReq,       // register access
    output logic [31:0]              regRdData,    // read data
    output logic                     regRdValid,   // read data strobe
    input  wire logic [15:0]         dioIn,        // field lines
    output logic [15:0]              dioFiltered,  // debounced lines
    output logic                     counterOut,   // waveform pin
    output logic                     counterIrq    // pending interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] dbLo_r;      // debounce fields, lines 0-7
    logic [31:0] dbHi_r;      // debounce fields, lines 8-15
    logic [31:0] ctrl_r;      // counter control
    logic [31:0] const1_r;    // first constant
    logic [31:0] const2_r;    // second constant
    logic        gie_r;       // global interrupt enable
    logic [31:0] const1Wr;    // first constant as written
    logic        wrDbLo;
    logic        wrDbHi;
    logic        wrCtrl;
    logic        wrConst1;
    logic        wrConst2;
    logic        wrTrig;
    logic        wrGie;
    logic [31:0] rdMux;       // selected read word

    // merge write data into a word under byte enables
    function automatic logic [31:0] mergeBe(input logic [31:0] oldV,
                                            input logic [31:0] newV,
                                            input logic [3:0]  be);
        logic [31:0] res;
        res = oldV;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = newV[8*b +: 8];
            end
        end
        return res;
    endfunction

    // address decode
    assign wrDbLo   = regReq.wr && (regReq.addr == mfct_pkg::OFS_DB_LO);
    assign wrDbHi   = regReq.wr && (regReq.addr == mfct_pkg::OFS_DB_HI);
    assign wrCtrl   = regReq.wr && (regReq.addr == mfct_pkg::OFS_CTRL);
    assign wrConst1 = regReq.wr && (regReq.addr == mfct_pkg::OFS_CONST1);
    assign wrConst2 = regReq.wr && (regReq.addr == mfct_pkg::OFS_CONST2);
    assign wrTrig   = regReq.wr && (regReq.addr == mfct_pkg::OFS_TRIG) && regReq.be[0] && regReq.data[0];
    assign wrGie    = regReq.wr && (regReq.addr == mfct_pkg::OFS_GIE) && regReq.be[0];
    assign const1Wr = mergeBe(const1_r, regReq.data, regReq.be);

    // register storage
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            dbLo_r   <= mfct_pkg::DB_RST;
            dbHi_r   <= mfct_pkg::DB_RST;
            ctrl_r   <= mfct_pkg::CTRL_RST;
            const1_r <= mfct_pkg::CONST_RST;
            const2_r <= mfct_pkg::CONST_RST;
            gie_r    <= 1'b0;
        end else begin
            if (wrDbLo) dbLo_r <= mergeBe(dbLo_r, regReq.data, regReq.be);
            if (wrDbHi) dbHi_r <= mergeBe(dbHi_r, regReq.data, regReq.be);
            // release bit is a strobe, never stored
            if (wrCtrl) ctrl_r <= mergeBe(ctrl_r, regReq.data, regReq.be) & ~(32'h1 << mfct_pkg::CF_RELEASE);
            if (wrConst1) const1_r <= const1Wr;
            if (wrConst2) const2_r <= mergeBe(const2_r, regReq.data, regReq.be);
            if (wrGie) gie_r <= regReq.data[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input synchronizer and debounce
    logic [15:0] sync1_r;     // first stage
    logic [15:0] sync2_r;     // second stage
    logic [15:0] deb;         // debounced levels
    logic [15:0] debPrev_r;   // debounced, one cycle late
    logic [63:0] dbAll;       // both debounce registers

    // line n field at bits 4n+2..4n
    assign dbAll = {dbHi_r, dbLo_r};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync1_r   <= 16'h0000;
            sync2_r   <= 16'h0000;
            debPrev_r <= 16'h0000;
        end else begin
            sync1_r   <= dioIn;
            sync2_r   <= sync1_r;
            debPrev_r <= deb;
        end
    end

    genvar g;
    for (g = 0; g < 16; g++) begin : gDeb
        logic [2:0]  code;     // this line's debounce code
        logic [18:0] limit;    // required stable cycles, 0 = off
        logic [18:0] cnt_r;    // stable-time counter
        logic        lvl_r;    // accepted level
        assign code = dbAll[4*g +: 3];
        // code to stable time, reserved codes filter nothing
        assign limit = (code == mfct_pkg::DB_4US)  ? 19'(mfct_pkg::DB_4US_CYC)  :
                       (code == mfct_pkg::DB_64US) ? 19'(mfct_pkg::DB_64US_CYC) :
                       (code == mfct_pkg::DB_1MS)  ? 19'(DB_1MS_CYC)            :
                       (code == mfct_pkg::DB_8MS)  ? 19'(DB_8MS_CYC)            : 19'h00000;
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                cnt_r <= 19'h00000;
                lvl_r <= 1'b0;
            end else if (limit == 19'h00000 || sync2_r[g] == lvl_r) begin
                cnt_r <= 19'h00000;
                lvl_r <= sync2_r[g];
            end else if (cnt_r >= limit - 19'h00001) begin
                cnt_r <= 19'h00000;
                lvl_r <= sync2_r[g];
            end else begin
                cnt_r <= cnt_r + 19'h00001;
            end
        end
        assign deb[g] = lvl_r;
    end

    assign dioFiltered = deb;

    ////////////////////////////////////////////////////////////////////////
    // count-rate enables
    localparam int RATES[3] = '{mfct_pkg::RATE_1M, mfct_pkg::RATE_4M, mfct_pkg::RATE_8M};
    logic [2:0] rateTick;     // 1, 4, 8 MHz enables

    // phase accumulators give exact average rates
    for (g = 0; g < 3; g++) begin : gRate
        logic [5:0] acc_r;
        logic [6:0] sum;
        assign sum = {1'b0, acc_r} + 7'(RATES[g]);
        always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
                acc_r <= 6'h00;
            end else if (sum >= 7'(mfct_pkg::CLK_MHZ)) begin
                acc_r <= 6'(sum - 7'(mfct_pkg::CLK_MHZ));
            end else begin
                acc_r <= sum[5:0];
            end
        end
        assign rateTick[g] = (sum >= 7'(mfct_pkg::CLK_MHZ));
    end

    ////////////////////////////////////////////////////////////////////////
    // control decode
    mfct_pkg::mfct_mode_e mode;
    logic [1:0] clkSrc;
    logic [1:0] inPol;
    logic       tick;         // selected count enable
    logic       inLvl;        // counter input active
    logic       inLvlPrev;
    logic       inEdge;       // counter input becomes active
    logic       trigEdge;     // external trigger edge
    logic       trig;         // selected trigger
    logic       gateAct;      // gate-off active and enabled
    logic       reload;       // watchdog reload request

    assign mode   = mfct_pkg::mfct_mode_e'(ctrl_r[mfct_pkg::CF_MODE +: 3]);
    assign clkSrc = ctrl_r[mfct_pkg::CF_CLKSRC +: 2];
    assign inPol  = ctrl_r[mfct_pkg::CF_INPOL +: 2];

    assign tick = (clkSrc == 2'h0) ? rateTick[0] :
                  (clkSrc == 2'h1) ? rateTick[1] :
                  (clkSrc == 2'h2) ? rateTick[2] :
                  (deb[mfct_pkg::CH_EXTCLK] & ~debPrev_r[mfct_pkg::CH_EXTCLK]);

    assign inLvl = (inPol == mfct_pkg::IP_LOW)  ? ~deb[mfct_pkg::CH_CNT_IN] :
                   (inPol == mfct_pkg::IP_HIGH) ?  deb[mfct_pkg::CH_CNT_IN] : 1'b0;
    assign inLvlPrev = (inPol == mfct_pkg::IP_LOW)  ? ~debPrev_r[mfct_pkg::CH_CNT_IN] :
                       (inPol == mfct_pkg::IP_HIGH) ?  debPrev_r[mfct_pkg::CH_CNT_IN] : 1'b0;
    assign inEdge = inLvl & ~inLvlPrev;

    assign trigEdge = ctrl_r[mfct_pkg::CF_TRGPOL] ?
                      ( deb[mfct_pkg::CH_TRIG] & ~debPrev_r[mfct_pkg::CH_TRIG]) :
                      (~deb[mfct_pkg::CH_TRIG] &  debPrev_r[mfct_pkg::CH_TRIG]);
    assign trig = ctrl_r[mfct_pkg::CF_TRGSRC] ? trigEdge : wrTrig;

    assign gateAct = ctrl_r[mfct_pkg::CF_GATEEN] &
                     (deb[mfct_pkg::CH_GATE] == ctrl_r[mfct_pkg::CF_GATEPOL]);
    // reload by constant write or input pulse
    assign reload = ctrl_r[mfct_pkg::CF_LOADSEL] ? inEdge : wrConst1;

    ////////////////////////////////////////////////////////////////////////
    // counter core
    mfct_pkg::mfct_state_e state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt;        // live count
    logic        phase_r, phase_nxt;    // PWM: 0 interval, 1 pulse
    logic        act_r, act_nxt;        // output active (PWM, watchdog)
    logic [7:0]  pulse_r, pulse_nxt;    // output pulse timer
    logic        evt;                   // interrupt-worthy event
    logic [31:0] evtStep;               // event count after step
    logic [31:0] ldVal;                 // watchdog reload value
    logic        outAct;                // output active, next cycle

    assign ldVal   = wrConst1 ? const1Wr : const1_r;
    assign evtStep = gateAct ? cnt_r - 32'h1 : cnt_r + 32'h1;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        phase_nxt = phase_r;
        act_nxt   = act_r;
        pulse_nxt = (pulse_r == 8'h00) ? 8'h00 : pulse_r - 8'h01;
        evt       = 1'b0;
        case (mode)
            mfct_pkg::MODE_PWM: begin
                if (trig) begin
                    // start with the interval, output inactive
                    state_nxt = mfct_pkg::CT_RUN;
                    cnt_nxt   = const1_r;
                    phase_nxt = 1'b0;
                    act_nxt   = 1'b0;
                end else if (state_r == mfct_pkg::CT_RUN && tick) begin
                    if (cnt_r == 32'h0) begin
                        phase_nxt = ~phase_r;
                        act_nxt   = ~phase_r;
                        cnt_nxt   = phase_r ? const1_r : const2_r;
                        evt       = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r - 32'h1;
                    end
                end
            end
            mfct_pkg::MODE_WDOG: begin
                if (reload) begin
                    cnt_nxt = ldVal;
                end
                if (trig) begin
                    // zero count times out at once
                    if (!reload && cnt_r == 32'h0) begin
                        state_nxt = mfct_pkg::CT_IDLE;
                        act_nxt   = 1'b0;
                        evt       = 1'b1;
                    end else begin
                        state_nxt = mfct_pkg::CT_RUN;
                        act_nxt   = 1'b1;
                    end
                end else if (state_r == mfct_pkg::CT_RUN && tick && !gateAct && !reload) begin
                    if (cnt_r == 32'h0) begin
                        state_nxt = mfct_pkg::CT_IDLE;
                        act_nxt   = 1'b0;
                        evt       = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r - 32'h1;
                    end
                end
            end
            mfct_pkg::MODE_EVENT: begin
                act_nxt = 1'b0;
                if (trig) begin
                    state_nxt = mfct_pkg::CT_RUN;
                    cnt_nxt   = 32'h0;
                end else if (state_r == mfct_pkg::CT_RUN && inEdge) begin
                    if (evtStep == const1_r) begin
                        cnt_nxt   = 32'h0;
                        pulse_nxt = 8'(mfct_pkg::OUT_PULSE_CYC);
                        evt       = 1'b1;
                    end else begin
                        cnt_nxt = evtStep;
                    end
                end
            end
            mfct_pkg::MODE_PWIDTH: begin
                act_nxt = 1'b0;
                if (trig) begin
                    state_nxt = mfct_pkg::CT_ARM;
                    cnt_nxt   = 32'h0;
                end else if (state_r == mfct_pkg::CT_ARM && inEdge) begin
                    state_nxt = mfct_pkg::CT_MEAS;
                end else if (state_r == mfct_pkg::CT_MEAS) begin
                    if (!inLvl) begin
                        state_nxt = mfct_pkg::CT_IDLE;
                        pulse_nxt = 8'(mfct_pkg::OUT_PULSE_CYC);
                        evt       = 1'b1;
                    end else if (tick && cnt_r != 32'hffff_ffff) begin
                        cnt_nxt = cnt_r + 32'h1;
                    end
                end
            end
            default: begin
                // disabled and unsupported modes stop
                state_nxt = mfct_pkg::CT_IDLE;
                act_nxt   = 1'b0;
            end
        endcase
    end

    assign outAct = act_nxt | (pulse_nxt != 8'h00);

    // core state registers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= mfct_pkg::CT_IDLE;
            cnt_r   <= 32'h0;
            phase_r <= 1'b0;
            act_r   <= 1'b0;
            pulse_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            phase_r <= phase_nxt;
            act_r   <= act_nxt;
            pulse_r <= pulse_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output pin, interrupt and read port
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            counterOut <= 1'b1;
            counterIrq <= 1'b0;
        end else begin
            counterOut <= ctrl_r[mfct_pkg::CF_OUTPOL] ? outAct : ~outAct;
            if (evt && ctrl_r[mfct_pkg::CF_INTEN] && gie_r) begin
                counterIrq <= 1'b1;
            end else if (wrCtrl && regReq.data[mfct_pkg::CF_RELEASE] && regReq.be[1]) begin
                counterIrq <= 1'b0;
            end
        end
    end

    // read select, unmapped reads zero
    assign rdMux = (regReq.addr == mfct_pkg::OFS_DB_LO)    ? dbLo_r   :
                   (regReq.addr == mfct_pkg::OFS_DB_HI)    ? dbHi_r   :
                   (regReq.addr == mfct_pkg::OFS_CTRL)     ? ctrl_r   :
                   (regReq.addr == mfct_pkg::OFS_CONST1)   ? const1_r :
                   (regReq.addr == mfct_pkg::OFS_CONST2)   ? const2_r :
                   (regReq.addr == mfct_pkg::OFS_READBACK) ? cnt_r    :
                   (regReq.addr == mfct_pkg::OFS_GIE)      ? {31'h0, gie_r} : 32'h0;

    // read data registered one cycle after request
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            regRdData  <= 32'h0;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regReq.rd;
            if (regReq.rd) regRdData <= rdMux;
        end
    end

endmodule // mfct_counter_timer

// file: mfct_pkg.sv
/*
  mfct_pkg: constants, types and register map of the multifunction
  counter/timer with per-line input debounce.
  Assumes a 50 MHz system clock; offsets are byte addresses of 32-bit words.
*/
package mfct_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLK_MHZ        = 50;       // system clock rate
    localparam int DB_4US_NS      = 4000;     // shortest debounce time
    localparam int DB_64US_NS     = 64000;    // second debounce time
    localparam int DB_1MS_NS      = 1000000;  // third debounce time
    localparam int DB_8MS_NS      = 8000000;  // longest debounce time
    localparam int OUT_PULSE_NS   = 4000;     // event/measure output pulse
    localparam int DB_4US_CYC     = (DB_4US_NS * CLK_MHZ + 999) / 1000;
    localparam int DB_64US_CYC    = (DB_64US_NS * CLK_MHZ + 999) / 1000;
    localparam int DB_1MS_CYC     = (DB_1MS_NS * CLK_MHZ + 999) / 1000;
    localparam int DB_8MS_CYC     = (DB_8MS_NS * CLK_MHZ + 999) / 1000;
    localparam int OUT_PULSE_CYC  = (OUT_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int RATE_1M        = 1;        // internal count rates in MHz
    localparam int RATE_4M        = 4;
    localparam int RATE_8M        = 8;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] OFS_DB_LO    = 8'h48;  // debounce, lines 0-7
    localparam logic [7:0] OFS_DB_HI    = 8'h4c;  // debounce, lines 8-15
    localparam logic [7:0] OFS_CTRL     = 8'h50;  // counter control
    localparam logic [7:0] OFS_CONST1   = 8'h54;  // first reload constant
    localparam logic [7:0] OFS_CONST2   = 8'h58;  // second reload constant
    localparam logic [7:0] OFS_READBACK = 8'h5c;  // live count
    localparam logic [7:0] OFS_TRIG     = 8'h60;  // software trigger
    localparam logic [7:0] OFS_GIE      = 8'h64;  // global interrupt enable

    // reset values
    localparam logic [31:0] DB_RST    = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] CONST_RST = 32'h0000_0000;

    // counter control field positions
    localparam int CF_MODE    = 0;   // [2:0] mode
    localparam int CF_OUTPOL  = 3;   // output active level
    localparam int CF_INPOL   = 4;   // [5:4] input polarity
    localparam int CF_TRGPOL  = 6;   // external trigger edge
    localparam int CF_TRGSRC  = 7;   // trigger source
    localparam int CF_INTEN   = 8;   // counter interrupt enable
    localparam int CF_CLKSRC  = 9;   // [10:9] clock source
    localparam int CF_LOADSEL = 11;  // watchdog reload source
    localparam int CF_RELEASE = 12;  // interrupt release, self clearing
    localparam int CF_GATEEN  = 13;  // gate-off enable
    localparam int CF_GATEPOL = 14;  // gate-off active level

    // digital lines used by the counter
    localparam int CH_CNT_IN = 2;
    localparam int CH_TRIG   = 3;
    localparam int CH_EXTCLK = 4;
    localparam int CH_GATE   = 5;

    // debounce codes and input polarity codes
    localparam logic [2:0] DB_OFF  = 3'h0;
    localparam logic [2:0] DB_4US  = 3'h1;
    localparam logic [2:0] DB_64US = 3'h2;
    localparam logic [2:0] DB_1MS  = 3'h3;
    localparam logic [2:0] DB_8MS  = 3'h4;
    localparam logic [1:0] IP_LOW  = 2'h1;
    localparam logic [1:0] IP_HIGH = 2'h2;

    typedef enum logic [2:0] {
        MODE_OFF0   = 3'b000,
        MODE_OFF1   = 3'b001,
        MODE_PWM    = 3'b010,
        MODE_WDOG   = 3'b011,
        MODE_EVENT  = 3'b100,
        MODE_PWIDTH = 3'b101,
        MODE_PERIOD = 3'b110,
        MODE_ONESHT = 3'b111
    } mfct_mode_e;

    typedef enum logic [1:0] {
        CT_IDLE = 2'b00,   // stopped
        CT_RUN  = 2'b01,   // counting
        CT_ARM  = 2'b10,   // waiting for pulse start
        CT_MEAS = 2'b11    // measuring pulse
    } mfct_state_e;

    // one register access
    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic        rd;
        logic [3:0]  be;
        logic [31:0] data;
    } mfct_req_s;

endpackage

// file: mfct_properties.sv
/* mfct_properties: port checker for mfct_counter_timer.
   assumes the bind below and one clock domain. */
`timescale 1ns/1ns
module mfct_properties #(
    parameter int DB_1MS_CYC = mfct_pkg::DB_1MS_CYC,
    parameter int DB_8MS_CYC = mfct_pkg::DB_8MS_CYC
) (
    input wire logic                clock,
    input wire logic                nrst,
    input wire mfct_pkg::mfct_req_s regReq,
    input wire logic [31:0]         regRdData,
    input wire logic                regRdValid,
    input wire logic [15:0]         dioIn,
    input wire logic [15:0]         dioFiltered,
    input wire logic                counterOut,
    input wire logic                counterIrq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    wire [7:0] a = regReq.addr; // request address
    // a release write on the control register
    wire relWr = regReq.wr && a == 8'h50 && regReq.be[1] && regReq.data[12];
    ////////////////////////////////////////
    rd_answer_a: assert property (regReq.rd |=> regRdValid)
        else $error("read not answered");
    no_stray_a: assert property (regRdValid |-> $past(regReq.rd))
        else $error("stray read strobe");
    rd_hold_a: assert property (!regRdValid |-> $stable(regRdData))
        else $error("read data moved");
    unmapped_zero_a: assert property (regReq.rd && (a < 8'h48 || a > 8'h64 || a[1:0] != 2'h0)
        |=> regRdData == 32'h0) else $error("unmapped read not zero");
    release_reads_a: assert property (regReq.rd && a == 8'h50 |=> !regRdData[12])
        else $error("release bit read high");
    db_store_a: assert property (regReq.wr && a == 8'h48 && regReq.be == 4'hf ##1 !regReq.wr ##1
        regReq.rd && a == 8'h48 && !regReq.wr |=> regRdData == $past(regReq.data, 3))
        else $error("debounce word not stored");
    irq_pending_a: assert property ($fell(counterIrq) |-> $past(relWr))
        else $error("interrupt dropped without release");
    filt_delay_a: assert property ($changed(dioFiltered) |-> ((dioFiltered ^ $past(dioFiltered))
        & (dioFiltered ^ $past(dioIn, 3))) == 16'h0) else $error("filtered level wrong");
    cover property ($rose(counterIrq));
    cover property ($fell(counterIrq));
    cover property ($changed(dioFiltered));
endmodule // mfct_properties
bind mfct_counter_timer mfct_properties #(.DB_1MS_CYC(DB_1MS_CYC), .DB_8MS_CYC(DB_8MS_CYC)) u_props (
    .clock(clock), .nrst(nrst), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
    .dioIn(dioIn), .dioFiltered(dioFiltered), .counterOut(counterOut), .counterIrq(counterIrq));

// file: mfct_field_model.sv
/* mfct_field_model: field lines; each change chatters 3 cycles.
   assumes lvlReq is set by the bench. */
`timescale 1ns/1ns
module mfct_field_model (
    input wire logic        clock,
    input wire logic [15:0] lvlReq,
    output logic [15:0]     dioOut
);
    logic [15:0] prevLvl = 16'h0; // last request seen
    logic [15:0] chgMask = 16'h0; // lines now bouncing
    int          bounce  = 0;     // chatter cycles left
    initial dioOut = 16'h0;
    always @(posedge clock) begin
        #2;
        if (lvlReq !== prevLvl) begin
            chgMask = lvlReq ^ prevLvl;
            bounce = 3;
        end
        prevLvl = lvlReq;
        dioOut = lvlReq ^ ((bounce % 2) ? chgMask : 16'h0);
        if (bounce > 0) bounce--;
    end
endmodule // mfct_field_model

// file: test_multifunction_counter_timer.sv
/* test_multifunction_counter_timer: directed scenarios.
   assumes the field model drives dioIn. */
`timescale 1ns/1ns
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin fail_count++; $display("MISMATCH %0t got %h", $time, g); end end
module test_multifunction_counter_timer;
    logic                clock = 1'b0;
    logic                nrst = 1'b0;
    mfct_pkg::mfct_req_s regReq = '0;
    logic [31:0]         regRdData;
    logic                regRdValid, counterOut, counterIrq;
    logic [15:0]         dioIn, dioFiltered, lvlReq = 16'h0;
    int                  fail_count = 0, n_compared = 0;
    initial forever #10 clock = ~clock;
    mfct_counter_timer #(.DB_1MS_CYC(20), .DB_8MS_CYC(40)) u_dut (.clock(clock), .nrst(nrst),
        .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid), .dioIn(dioIn),
        .dioFiltered(dioFiltered), .counterOut(counterOut), .counterIrq(counterIrq));
    mfct_field_model u_field (.clock(clock), .lvlReq(lvlReq), .dioOut(dioIn));
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        tick(1);
        regReq = '{addr:a, wr:1'b1, rd:1'b0, be:be, data:d};
        tick(1);
        regReq.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] w);
        tick(1);
        regReq = '{addr:a, wr:1'b0, rd:1'b1, be:4'h0, data:32'h0};
        tick(1);
        regReq.rd = 1'b0;
        `CHK(regRdValid, 1'b1)
        `CHK(regRdData, w)
    endtask
    task automatic waitOut(input logic v, output int n);
        for (n = 0; counterOut !== v; n++) begin
            tick(1);
            if (n > 400) begin
                fail_count++;
                $display("MISMATCH %0t wait timed out", $time);
                summarize();
            end
        end
    endtask
    task automatic pulse(input int w, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 520; i++) begin
            lvlReq[2] = (i < w);
            tick(1);
            seen |= counterOut;
        end
    endtask
    task automatic t_regs();
        rd(8'h48, 32'h0);
        rd(8'h4c, 32'h0);
        wr(8'h48, 4'hf, 32'hcba9_8888);
        rd(8'h48, 32'hcba9_8888);
        wr(8'h4c, 4'h2, 32'h8800);
        rd(8'h4c, 32'h8800);
        rd(8'h44, 32'h0);
        wr(8'h48, 4'hf, 32'h100);
    endtask
    task automatic t_pwm();
        int n;
        wr(8'h64, 4'h1, 32'h1);
        wr(8'h54, 4'hf, 32'h3);
        wr(8'h58, 4'hf, 32'h2);
        wr(8'h50, 4'h3, 32'h10a);
        wr(8'h60, 4'h1, 32'h1);
        waitOut(1'b1, n);
        waitOut(1'b0, n);
        `CHK(n, 150)
        waitOut(1'b1, n);
        `CHK(n, 200)
        `CHK(counterIrq, 1'b1)
        wr(8'h50, 4'h3, 32'h1000);
        tick(2);
        `CHK(counterIrq, 1'b0)
    endtask
    task automatic t_wdog();
        int n;
        wr(8'h50, 4'h3, 32'h10b);
        wr(8'h54, 4'hf, 32'h2);
        wr(8'h60, 4'h1, 32'h1);
        waitOut(1'b1, n);
        waitOut(1'b0, n);
        `CHK(n >= 100 && n <= 155, 1'b1)
        rd(8'h5c, 32'h0);
        `CHK(counterIrq, 1'b1)
        wr(8'h50, 4'h3, 32'h110b);
        `CHK(counterIrq, 1'b0)
        wr(8'h60, 4'h1, 32'h1);
        tick(4);
        `CHK(counterIrq, 1'b1)
    endtask
    task automatic t_event();
        logic s;
        wr(8'h50, 4'h3, 32'h112c);
        wr(8'h54, 4'hf, 32'h2);
        wr(8'h60, 4'h1, 32'h1);
        pulse(50, s);
        rd(8'h5c, 32'h0);
        pulse(260, s);
        rd(8'h5c, 32'h1);
        `CHK(counterIrq, 1'b0)
        pulse(260, s);
        `CHK(s, 1'b1)
        rd(8'h5c, 32'h0);
        `CHK(counterIrq, 1'b1)
        lvlReq[5] = 1'b1;
        wr(8'h50, 4'h3, 32'h612c);
        pulse(260, s);
        rd(8'h5c, 32'hffff_ffff);
    endtask
    task automatic t_meas();
        logic s;
        wr(8'h50, 4'h3, 32'h14ed);
        lvlReq[3] = 1'b1;
        tick(10);
        `CHK(dioFiltered[3], 1'b1)
        pulse(250, s);
        `CHK(s, 1'b1)
        regReq = '{addr:8'h5c, wr:1'b0, rd:1'b1, be:4'h0, data:32'h0};
        tick(1);
        regReq.rd = 1'b0;
        `CHK(regRdData >= 32'd39 && regRdData <= 32'd41, 1'b1)
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        tick(10);
        nrst = 1'b1;
        t_regs();
        t_pwm();
        t_wdog();
        t_event();
        t_meas();
        summarize();
    end
endmodule // test_multifunction_counter_timer
